// ---- common/sbc_pkg.sv ----
/*
  Shared constants for the slot-bus control block.
  Assumes one system clock and no software-visible registers.
*/
package sbc_pkg;

  // Bit positions inside the refresh control byte.
  localparam int unsigned SUSP_EN_BIT = 7;
  localparam int unsigned CPU_OFF_BIT = 6;

  // Bus clock division codes in the low clock control bits.
  localparam logic [1:0] DIV_CODE_2 = 2'h0;
  localparam logic [1:0] DIV_CODE_4 = 2'h1;
  localparam logic [1:0] DIV_CODE_6 = 2'h2;
  localparam logic [1:0] DIV_CODE_8 = 2'h3;
  localparam int unsigned SRC_SEL_BIT = 2;
  localparam int unsigned DIV_SEL_LO  = 0;

  // Bus reset stretch in oscillator edges.
  localparam logic [3:0] RST_HOLD_EDGES = 4'hF;

  // Default command length in bus clock halves, and least length on early end.
  localparam logic [3:0] CYC_DEFAULT_LEN = 4'hC;
  localparam logic [3:0] CYC_MIN_LEN     = 4'h2;

  // Refresh strobe low time in bus clock halves.
  localparam logic [3:0] REF_STROBE_LEN = 4'h4;

  // Address boundary of the first megabyte.
  localparam logic [23:0] LOW_MEG_LIMIT = 24'h100000;

  // Refresh address counter width and its reset value.
  localparam int unsigned REF_ADDR_W = 9;
  localparam logic [REF_ADDR_W-1:0] REF_ADDR_RST = 9'h000;

  typedef enum logic [1:0] {
    SBC_IDLE = 2'b00,
    SBC_CMD  = 2'b01,
    SBC_REF  = 2'b10,
    SBC_DONE = 2'b11
  } sbc_state_e;

endpackage : sbc_pkg

// ---- core/sbc_clkdiv.sv ----
/*
  Bus clock divider over the doubled CPU clock or the bus oscillator.
  Assumes the source inputs toggle no faster than half the system clock.
*/
`timescale 1ns/1ps
`default_nettype none
module sbc_clkdiv
  import sbc_pkg::*;
(
  // Clock and reset.
  input  wire logic       i_sys_clk,
  input  wire logic       i_rstn,
  // Sources and selection.
  input  wire logic       i_cpu_clock_x2,
  input  wire logic       i_bus_osc_in,
  input  wire logic [3:0] i_clock_control_reg,
  // Outputs.
  output logic            o_bus_clk,
  output logic            o_bus_clk_tick,
  output logic            o_osc_tick
);

  logic       src_q;
  logic       osc_q;
  logic [2:0] cnt;
  logic       next_src_q;
  logic       next_osc_q;
  logic [2:0] next_cnt;
  logic       next_bus_clk;
  logic       src;
  logic       src_edge;
  logic [2:0] half_len;

  // Half-period in source edges for each division code.
  function automatic logic [2:0] half_of(input logic [1:0] code);
    unique case (code)
      DIV_CODE_2: half_of = 3'h1;
      DIV_CODE_4: half_of = 3'h2;
      DIV_CODE_6: half_of = 3'h3;
      DIV_CODE_8: half_of = 3'h4;
    endcase
  endfunction : half_of

  always_comb begin
    src        = i_clock_control_reg[SRC_SEL_BIT] ? i_bus_osc_in : i_cpu_clock_x2;
    src_edge   = src & ~src_q;
    half_len   = half_of(i_clock_control_reg[DIV_SEL_LO +: 2]);
    next_src_q = src;
    next_osc_q = i_bus_osc_in;
    next_cnt   = cnt;
    next_bus_clk = o_bus_clk;
    o_bus_clk_tick = 1'b0;
    if (src_edge) begin
      if (cnt + 3'h1 >= half_len) begin
        next_cnt       = 3'h0;
        next_bus_clk   = ~o_bus_clk;
        o_bus_clk_tick = 1'b1;
      end else begin
        next_cnt = cnt + 3'h1;
      end
    end
    o_osc_tick = i_bus_osc_in & ~osc_q;
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      src_q     <= 1'b0;
      osc_q     <= 1'b0;
      cnt       <= 3'h0;
      o_bus_clk <= 1'b0;
    end else begin
      src_q     <= next_src_q;
      osc_q     <= next_osc_q;
      cnt       <= next_cnt;
      o_bus_clk <= next_bus_clk;
    end
  end

endmodule : sbc_clkdiv
`default_nettype wire

// ---- core/sbc_busrst.sv ----
/*
  Bus reset: active high from power-on reset until a fixed count of
  oscillator edges has passed.
  Assumes the oscillator tick is a one-cycle pulse in the system domain.
*/
`timescale 1ns/1ps
`default_nettype none
module sbc_busrst
  import sbc_pkg::*;
(
  // Clock and reset.
  input  wire logic i_sys_clk,
  input  wire logic i_rstn,
  // Timing source.
  input  wire logic i_osc_tick,
  // Output.
  output logic      o_bus_reset_out
);

  logic [3:0] cnt;
  logic [3:0] next_cnt;
  logic       next_rst;

  always_comb begin
    next_cnt = cnt;
    next_rst = o_bus_reset_out;
    if (i_osc_tick) begin
      if (cnt != RST_HOLD_EDGES) begin
        next_cnt = cnt + 4'h1;
      end else begin
        next_rst = 1'b0;
      end
    end
  end

  // Release only on an oscillator edge keeps the slot reset aligned to it.
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      cnt             <= 4'h0;
      o_bus_reset_out <= 1'b1;
    end else begin
      cnt             <= next_cnt;
      o_bus_reset_out <= next_rst;
    end
  end

endmodule : sbc_busrst
`default_nettype wire

// ---- core/sbc_slot_ctl.sv ----
/*
  Slot bus control top: refresh strobing and sensing, bus reset, low-memory
  strobes, byte-high enable, bus clock, terminal count, early termination
  and suspend-mode selection.
  Assumes pins synchronous to i_sys_clk and a pull-up on the refresh wire.
*/
// Operation
// - Suspend enable set and suspend input low selects slow refresh, stops peripheral clock.
// - In suspend, the cpu-off bit chooses between CPU off and CPU on.
// - Refresh line is pulled low when a refresh cycle begins, unless an outside master already holds it low.
// - Refresh line is sampled; an external low is taken as refresh request.
// - Each refresh strobe advances refresh address and selects the mapper entry.
// - Refresh line is only driven low or released, never driven high.
// - Bus reset is active high from power-on reset, timed to oscillator.
// - Low-memory read strobe active in refresh and reads below 1 MB.
// - Low-memory write strobe active only in writes below 1 MB.
// - CPU cycles time byte-high enable with address, decoded from byte enables.
// - In 8-bit DMA, byte-high enable is the inverse of address bit 0.
// - Bus clock is half, quarter, sixth or eighth of selected source.
// - Latch enable and command strobes change only on bus clock edges.
// - Terminal count output asserts whenever any DMA channel hits terminal count.
// - Zero-wait terminate low ends a CPU bus cycle before default length.
`timescale 1ns/1ps
`default_nettype none
module sbc_slot_ctl
  import sbc_pkg::*;
(
  // Clock and reset.
  input  wire logic                  i_sys_clk,
  input  wire logic                  i_rstn,
  // Clock sources and control bytes.
  input  wire logic                  i_cpu_clock_x2,
  input  wire logic                  i_bus_osc_in,
  input  wire logic [3:0]            i_clock_control_reg,
  input  wire logic [7:0]            i_refresh_control_reg,
  input  wire logic                  i_suspend_n,
  input  wire logic                  i_slow_ref_tick,
  input  wire logic                  i_ref_timer_tick,
  // Cycle request from the internal bus controller.
  input  wire logic                  i_cyc_start,
  input  wire logic                  i_cyc_mem,
  input  wire logic                  i_cyc_write,
  input  wire logic                  i_cyc_dma,
  input  wire logic                  i_cyc_dma16,
  input  wire logic [23:0]           i_cyc_addr,
  input  wire logic                  i_cpu_byte_low_enable_n,
  input  wire logic                  i_cpu_byte_high_enable_n,
  input  wire logic                  i_zero_wait_terminate_n,
  input  wire logic [7:0]            i_dma_tc,
  // Refresh open-drain line.
  input  wire logic                  i_refresh_n,
  output logic                       o_refresh_n,
  output logic                       o_refresh_oe,
  // Slot bus outputs.
  output logic                       o_bus_clk,
  output logic                       o_bus_reset_out,
  output logic                       o_ale,
  output logic                       o_ior_n,
  output logic                       o_iow_n,
  output logic                       o_memr_n,
  output logic                       o_memw_n,
  output logic                       o_smemr_n,
  output logic                       o_smemw_n,
  output logic                       o_sbhe_n,
  output logic [23:0]                o_slot_addr,
  output logic                       o_tc,
  output logic                       o_cyc_done,
  // Refresh address and power state.
  output logic [REF_ADDR_W-1:0]      o_ref_addr,
  output logic                       o_mapper_ref_sel,
  output logic                       o_suspend_active,
  output logic                       o_cpu_clk_en,
  output logic                       o_periph_clk_en
);

  logic                  bus_clk_tick;
  logic                  osc_tick;
  sbc_state_e            state;
  sbc_state_e            next_state;
  logic [3:0]            len;
  logic [3:0]            next_len;
  logic                  pend_cyc;
  logic                  next_pend_cyc;
  logic                  pend_ref;
  logic                  next_pend_ref;
  logic                  cur_mem;
  logic                  cur_write;
  logic                  cur_low;
  logic                  next_cur_mem;
  logic                  next_cur_write;
  logic                  next_cur_low;
  logic                  drv_ref;
  logic                  next_drv_ref;
  logic                  ext_ref_q;
  logic                  next_ext_ref_q;
  logic                  ref_in_low;
  logic                  ext_ref_start;
  logic [REF_ADDR_W-1:0] next_ref_addr;
  logic                  next_ale;
  logic                  next_ior_n;
  logic                  next_iow_n;
  logic                  next_memr_n;
  logic                  next_memw_n;
  logic                  next_smemr_n;
  logic                  next_smemw_n;
  logic                  next_sbhe_n;
  logic [23:0]           next_slot_addr;
  logic                  next_tc;
  logic                  susp;
  logic                  ref_tick;
  logic [23:0]           req_addr;
  logic                  req_dma;
  logic                  req_dma16;
  logic                  req_ble_n;
  logic                  req_bhe_n;
  logic                  next_req_dma;
  logic                  next_req_dma16;
  logic                  next_req_ble_n;
  logic                  next_req_bhe_n;
  logic [23:0]           next_req_addr;

  sbc_clkdiv u_clkdiv (
    .i_sys_clk           (i_sys_clk),
    .i_rstn              (i_rstn),
    .i_cpu_clock_x2      (i_cpu_clock_x2),
    .i_bus_osc_in        (i_bus_osc_in),
    .i_clock_control_reg (i_clock_control_reg),
    .o_bus_clk           (o_bus_clk),
    .o_bus_clk_tick      (bus_clk_tick),
    .o_osc_tick          (osc_tick)
  );

  sbc_busrst u_busrst (
    .i_sys_clk       (i_sys_clk),
    .i_rstn          (i_rstn),
    .i_osc_tick      (osc_tick),
    .o_bus_reset_out (o_bus_reset_out)
  );

  // Byte-high enable for CPU, 8-bit DMA and 16-bit DMA cycles.
  function automatic logic sbhe_of(input logic dma, input logic dma16, input logic a0,
                                   input logic ble_n, input logic bhe_n);
    if (dma && dma16) begin
      sbhe_of = 1'b0;
    end else if (dma) begin
      sbhe_of = ~a0;
    end else begin
      sbhe_of = bhe_n | (~ble_n & a0 & bhe_n);
    end
  endfunction : sbhe_of

  always_comb begin
    susp             = i_refresh_control_reg[SUSP_EN_BIT] & ~i_suspend_n;
    o_suspend_active = susp;
    o_cpu_clk_en     = ~(susp & i_refresh_control_reg[CPU_OFF_BIT]);
    o_periph_clk_en  = ~susp;
    ref_tick         = susp ? i_slow_ref_tick : i_ref_timer_tick;
    ref_in_low       = ~i_refresh_n;
    ext_ref_start    = ref_in_low & ~ext_ref_q & ~drv_ref;
    o_refresh_n      = 1'b0;
    o_refresh_oe     = drv_ref;
    o_mapper_ref_sel = drv_ref | ref_in_low;
  end

  always_comb begin
    next_state     = state;
    next_len       = len;
    next_pend_cyc  = pend_cyc | i_cyc_start;
    next_pend_ref  = pend_ref | ref_tick | ext_ref_start;
    next_cur_mem   = cur_mem;
    next_cur_write = cur_write;
    next_cur_low   = cur_low;
    next_drv_ref   = drv_ref;
    next_ext_ref_q = ref_in_low;
    next_ref_addr  = o_ref_addr;
    next_ale       = o_ale;
    next_ior_n     = o_ior_n;
    next_iow_n     = o_iow_n;
    next_memr_n    = o_memr_n;
    next_memw_n    = o_memw_n;
    next_smemr_n   = o_smemr_n;
    next_smemw_n   = o_smemw_n;
    next_sbhe_n    = o_sbhe_n;
    next_slot_addr = o_slot_addr;
    next_tc        = |i_dma_tc;
    next_req_addr  = req_addr;
    next_req_dma   = req_dma;
    next_req_dma16 = req_dma16;
    next_req_ble_n = req_ble_n;
    next_req_bhe_n = req_bhe_n;
    o_cyc_done     = 1'b0;
    if (i_cyc_start) begin
      next_req_addr  = i_cyc_addr;
      next_req_dma   = i_cyc_dma;
      next_req_dma16 = i_cyc_dma16;
      next_req_ble_n = i_cpu_byte_low_enable_n;
      next_req_bhe_n = i_cpu_byte_high_enable_n;
      next_cur_mem   = i_cyc_mem;
      next_cur_write = i_cyc_write;
      next_cur_low   = i_cyc_addr < LOW_MEG_LIMIT;
    end
    // Strobes move only on bus clock edges so slots see bus-clock timing.
    if (bus_clk_tick) begin
      unique case (state)
        SBC_IDLE: begin
          if (pend_ref) begin
            next_pend_ref = ref_tick | ext_ref_start;
            next_drv_ref  = ~ext_ref_q;
            next_ref_addr = o_ref_addr + 9'h001;
            next_smemr_n  = 1'b0;
            next_memr_n   = 1'b0;
            next_len      = 4'h0;
            next_state    = SBC_REF;
          end else if (pend_cyc) begin
            next_pend_cyc  = i_cyc_start;
            next_ale       = 1'b1;
            next_slot_addr = req_addr;
            next_sbhe_n    = sbhe_of(req_dma, req_dma16, req_addr[0], req_ble_n,
                                     req_bhe_n);
            next_len       = 4'h0;
            next_state     = SBC_CMD;
          end
        end
        SBC_CMD: begin
          next_ale = 1'b0;
          next_len = len + 4'h1;
          if (len == 4'h0) begin
            next_memr_n  = ~(cur_mem & ~cur_write);
            next_memw_n  = ~(cur_mem & cur_write);
            next_ior_n   = ~(~cur_mem & ~cur_write);
            next_iow_n   = ~(~cur_mem & cur_write);
            next_smemr_n = ~(cur_mem & ~cur_write & cur_low);
            next_smemw_n = ~(cur_mem & cur_write & cur_low);
          end else if ((len >= CYC_DEFAULT_LEN) ||
                       (!i_zero_wait_terminate_n && !req_dma && len >= CYC_MIN_LEN)) begin
            next_state = SBC_DONE;
          end
        end
        SBC_REF: begin
          next_len = len + 4'h1;
          if (len >= REF_STROBE_LEN) begin
            next_drv_ref = 1'b0;
            next_state   = SBC_DONE;
          end
        end
        SBC_DONE: begin
          next_memr_n  = 1'b1;
          next_memw_n  = 1'b1;
          next_ior_n   = 1'b1;
          next_iow_n   = 1'b1;
          next_smemr_n = 1'b1;
          next_smemw_n = 1'b1;
          o_cyc_done   = 1'b1;
          next_state   = SBC_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state       <= SBC_IDLE;
      len         <= 4'h0;
      pend_cyc    <= 1'b0;
      pend_ref    <= 1'b0;
      cur_mem     <= 1'b0;
      cur_write   <= 1'b0;
      cur_low     <= 1'b0;
      drv_ref     <= 1'b0;
      ext_ref_q   <= 1'b0;
      o_ref_addr  <= REF_ADDR_RST;
      o_ale       <= 1'b0;
      o_ior_n     <= 1'b1;
      o_iow_n     <= 1'b1;
      o_memr_n    <= 1'b1;
      o_memw_n    <= 1'b1;
      o_smemr_n   <= 1'b1;
      o_smemw_n   <= 1'b1;
      o_sbhe_n    <= 1'b1;
      o_slot_addr <= 24'h000000;
      o_tc        <= 1'b0;
      req_addr    <= 24'h000000;
      req_dma     <= 1'b0;
      req_dma16   <= 1'b0;
      req_ble_n   <= 1'b1;
      req_bhe_n   <= 1'b1;
    end else begin
      state       <= next_state;
      len         <= next_len;
      pend_cyc    <= next_pend_cyc;
      pend_ref    <= next_pend_ref;
      cur_mem     <= next_cur_mem;
      cur_write   <= next_cur_write;
      cur_low     <= next_cur_low;
      drv_ref     <= next_drv_ref;
      ext_ref_q   <= next_ext_ref_q;
      o_ref_addr  <= next_ref_addr;
      o_ale       <= next_ale;
      o_ior_n     <= next_ior_n;
      o_iow_n     <= next_iow_n;
      o_memr_n    <= next_memr_n;
      o_memw_n    <= next_memw_n;
      o_smemr_n   <= next_smemr_n;
      o_smemw_n   <= next_smemw_n;
      o_sbhe_n    <= next_sbhe_n;
      o_slot_addr <= next_slot_addr;
      o_tc        <= next_tc;
      req_addr    <= next_req_addr;
      req_dma     <= next_req_dma;
      req_dma16   <= next_req_dma16;
      req_ble_n   <= next_req_ble_n;
      req_bhe_n   <= next_req_bhe_n;
    end
  end

endmodule : sbc_slot_ctl
`default_nettype wire

// ---- verif/sbc_slot_ctl_properties.sv ----
/* Port-level checker for the slot-bus control top.
   Assumes the bench binds it to sbc_slot_ctl. */
`timescale 1ns/1ps
`default_nettype none
module sbc_slot_ctl_properties
  import sbc_pkg::*;
(
  // Clock and reset.
  input wire logic                  i_sys_clk,
  input wire logic                  i_rstn,
  // Inputs watched.
  input wire logic                  i_bus_osc_in,
  input wire logic [7:0]            i_refresh_control_reg,
  input wire logic                  i_suspend_n,
  input wire logic [7:0]            i_dma_tc,
  // Outputs watched.
  input wire logic                  o_refresh_n,
  input wire logic                  o_refresh_oe,
  input wire logic                  o_bus_clk,
  input wire logic                  o_bus_reset_out,
  input wire logic                  o_ale,
  input wire logic                  o_memr_n,
  input wire logic                  o_memw_n,
  input wire logic                  o_smemr_n,
  input wire logic                  o_smemw_n,
  input wire logic [23:0]           o_slot_addr,
  input wire logic                  o_tc,
  input wire logic [REF_ADDR_W-1:0] o_ref_addr,
  input wire logic                  o_suspend_active,
  input wire logic                  o_cpu_clk_en,
  input wire logic                  o_periph_clk_en
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rstn);

  // Oscillator edges seen since reset.
  logic       osc_prev;
  logic [7:0] osc_cnt;
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      osc_prev <= 1'b0;
      osc_cnt  <= 8'h00;
    end else begin
      osc_prev <= i_bus_osc_in;
      if (i_bus_osc_in && !osc_prev && osc_cnt != 8'hFF) begin
        osc_cnt <= osc_cnt + 8'h01;
      end
    end
  end

  a_refresh_never_high: assert property (o_refresh_n == 1'b0)
    else $error("Refresh line driven high");
  a_refresh_start_read: assert property ($rose(o_refresh_oe) |-> !o_memr_n && !o_smemr_n)
    else $error("Refresh began without read strobes");
  a_ref_addr_step: assert property ($rose(o_refresh_oe) |-> o_ref_addr == $past(o_ref_addr) + 1'b1)
    else $error("Refresh address did not advance by one");
  a_bus_reset_hold: assert property (osc_cnt < 8'h0F |-> o_bus_reset_out)
    else $error("Bus reset ended too early");
  a_suspend_select: assert property (o_suspend_active == (i_refresh_control_reg[SUSP_EN_BIT]
    && !i_suspend_n) && (o_suspend_active -> !o_periph_clk_en))
    else $error("Suspend state or clock stop wrong");
  a_cpu_off_choice: assert property (o_suspend_active |->
    o_cpu_clk_en == !i_refresh_control_reg[CPU_OFF_BIT])
    else $error("CPU clock choice in suspend wrong");
  a_low_write_range: assert property (!o_smemw_n |-> !o_memw_n && o_slot_addr < LOW_MEG_LIMIT)
    else $error("Low write strobe outside first megabyte");
  a_strobe_on_tick: assert property ($changed(o_ale) || $changed(o_memr_n) || $changed(o_memw_n)
    |-> $changed(o_bus_clk))
    else $error("Command strobe changed off a bus clock edge");
  a_tc_follow: assert property (1'b1 |=> o_tc == (|$past(i_dma_tc)))
    else $error("Terminal count output wrong");
endmodule : sbc_slot_ctl_properties
`default_nettype wire

// ---- verif/sbc_slot_peer.sv ----
/* Far-side model: the refresh wire's pull-up, an outside master that sinks it,
   and a slot card that can end a cycle early. Assumes bench commands on falling edges. */
`timescale 1ns/1ps
`default_nettype none
module sbc_slot_peer (
  // Clock.
  input  wire logic i_sys_clk,
  // Commands from the bench.
  input  wire logic i_ext_pull,
  input  wire logic i_ws_en,
  // Device pins.
  input  wire logic i_refresh_n,
  input  wire logic i_refresh_oe,
  input  wire logic i_cmd_n,
  // Resolved lines.
  output logic      o_refresh_wire,
  output logic      o_zero_wait_n
);
  // Open drain: released, the wire goes to the pull-up level.
  assign o_refresh_wire = !((i_refresh_oe && !i_refresh_n) || i_ext_pull);
  // The card reacts one clock after it sees a command strobe.
  always_ff @(posedge i_sys_clk) begin
    o_zero_wait_n <= !(i_ws_en && !i_cmd_n);
  end
endmodule : sbc_slot_peer
`default_nettype wire

// ---- verif/sbc_slot_ctl_bench.sv ----
/* Self-checking bench for the slot-bus control top.
   Assumes the far-side model sbc_slot_peer and a 20 MHz clock. */
`timescale 1ns/1ps
`default_nettype none
module sbc_slot_ctl_bench;
  import sbc_pkg::*;
  logic                  clk = 1'b0, rstn = 1'b0, cx2 = 1'b0, osc = 1'b0;
  logic [1:0]            ocnt = 2'h0;
  logic [3:0]            cc = 4'h0;
  logic [7:0]            rc = 8'h00, tcin = 8'h00;
  logic [23:0]           addr = 24'h000000, saddr;
  logic                  susp_n = 1'b1, slow_t = 1'b0, tmr_t = 1'b0, start = 1'b0;
  logic                  mem = 1'b0, wr = 1'b0, dma = 1'b0, d16 = 1'b0, dn = 1'b0;
  logic                  ble_n = 1'b0, bhe_n = 1'b1, ext_pull = 1'b0, ws_en = 1'b0;
  logic                  refn, oe, bclk, brst, ale, ior_n, iow_n, memr_n, memw_n;
  logic                  smemr_n, smemw_n, sbhe_n, tc, done, msel, sact, cpu_en, per_en;
  logic [REF_ADDR_W-1:0] raddr;
  wire logic             ref_w, zw_n;
  wire logic             cmd_n = memr_n & memw_n & ior_n & iow_n;
  int                    errors = 0, checked = 0, cyc = 0;

  always #25 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;
  always @(posedge clk) dn <= done;
  always @(negedge clk) begin
    cx2 <= ~cx2;
    ocnt <= ocnt + 2'h1;
    osc <= ocnt[1];
  end

  sbc_slot_ctl dut_u (
    .i_sys_clk(clk), .i_rstn(rstn), .i_cpu_clock_x2(cx2), .i_bus_osc_in(osc),
    .i_clock_control_reg(cc), .i_refresh_control_reg(rc), .i_suspend_n(susp_n),
    .i_slow_ref_tick(slow_t), .i_ref_timer_tick(tmr_t), .i_cyc_start(start),
    .i_cyc_mem(mem), .i_cyc_write(wr), .i_cyc_dma(dma), .i_cyc_dma16(d16),
    .i_cyc_addr(addr), .i_cpu_byte_low_enable_n(ble_n),
    .i_cpu_byte_high_enable_n(bhe_n), .i_zero_wait_terminate_n(zw_n),
    .i_dma_tc(tcin), .i_refresh_n(ref_w), .o_refresh_n(refn), .o_refresh_oe(oe),
    .o_bus_clk(bclk), .o_bus_reset_out(brst), .o_ale(ale), .o_ior_n(ior_n),
    .o_iow_n(iow_n), .o_memr_n(memr_n), .o_memw_n(memw_n), .o_smemr_n(smemr_n),
    .o_smemw_n(smemw_n), .o_sbhe_n(sbhe_n), .o_slot_addr(saddr), .o_tc(tc),
    .o_cyc_done(done), .o_ref_addr(raddr), .o_mapper_ref_sel(msel),
    .o_suspend_active(sact), .o_cpu_clk_en(cpu_en), .o_periph_clk_en(per_en));
  sbc_slot_peer peer_u (.i_sys_clk(clk), .i_ext_pull(ext_pull), .i_ws_en(ws_en),
    .i_refresh_n(refn), .i_refresh_oe(oe), .i_cmd_n(cmd_n), .o_refresh_wire(ref_w),
    .o_zero_wait_n(zw_n));

  task automatic chk(input string nm, input logic [23:0] seen, input logic [23:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic final_report;
    if (errors == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : final_report

  task automatic lim(input int n, input string nm);
    if (n >= 400) begin
      errors++;
      $display("Error %s timed out", nm);
      final_report();
    end
  endtask : lim

  task automatic until_done;
    int n;
    for (n = 0; dn !== 1'b1 && n < 400; n++) @(negedge clk);
    lim(n, "done");
    @(negedge clk);
  endtask : until_done

  task automatic rise;
    int n;
    for (n = 0; bclk !== 1'b0 && n < 400; n++) @(negedge clk);
    while (bclk !== 1'b1 && n < 400) begin
      @(negedge clk);
      n++;
    end
    lim(n, "bus clock");
  endtask : rise

  task automatic t_div(input logic [3:0] c, input int per);
    int t0;
    cc = c;
    repeat (3) rise();
    t0 = cyc;
    rise();
    chk("bus clock period", 24'(cyc - t0), 24'(per));
  endtask : t_div

  // Own refresh, or one asked for by an outside master.
  task automatic t_ref(input logic ext);
    logic [REF_ADDR_W-1:0] a0;
    int n;
    a0 = raddr;
    ext_pull = ext;
    tmr_t = !ext;
    @(negedge clk);
    tmr_t = 1'b0;
    for (n = 0; memr_n !== 1'b0 && n < 400; n++) @(negedge clk);
    lim(n, "refresh start");
    chk("refresh drive", 24'(oe), 24'(!ext));
    chk("refresh wire", 24'(ref_w), 24'h0);
    chk("refresh addr", 24'(raddr), 24'(a0 + 1'b1));
    chk("mapper select", 24'(msel), 24'h1);
    chk("low read", 24'(smemr_n), 24'h0);
    until_done();
    ext_pull = 1'b0;
    chk("refresh release", 24'(oe), 24'h0);
  endtask : t_ref

  // Expected bits are byte-high enable, low read strobe, low write strobe.
  task automatic t_cyc(input logic m, input logic w, input logic d, input logic s,
      input logic [23:0] a, input logic bh, input logic ws, input logic [2:0] ex,
      output int len);
    int n;
    logic sb, sr, sw, si;
    @(negedge clk);
    {mem, wr, dma, d16, addr, bhe_n, ws_en} = {m, w, d, s, a, bh, ws};
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
    {sb, sr, sw, si} = 4'hF;
    for (n = 0; dn !== 1'b1 && n < 400; n++) begin
      if (ale === 1'b1) sb = sbhe_n;
      sr = sr & smemr_n;
      sw = sw & smemw_n;
      si = si & (w ? iow_n : ior_n);
      @(negedge clk);
    end
    lim(n, "cycle end");
    ws_en = 1'b0;
    len = n;
    chk("byte high", 24'(sb), 24'(ex[2]));
    chk("low read", 24'(sr), 24'(ex[1]));
    chk("low write", 24'(sw), 24'(ex[0]));
    chk("io strobe", 24'(si), 24'(m));
  endtask : t_cyc

  task automatic t_susp;
    int k, n;
    for (k = 0; k < 8; k++) begin
      @(negedge clk);
      rc = {k[2], k[1], 6'h00};
      susp_n = k[0];
      @(negedge clk);
      chk("suspend", 24'(sact), 24'(k[2] & !k[0]));
      if (k[2] & !k[0]) begin
        chk("periph clock", 24'(per_en), 24'h0);
        chk("cpu clock", 24'(cpu_en), 24'(!k[1]));
      end
    end
    susp_n = 1'b0;
    slow_t = 1'b1;
    @(negedge clk);
    slow_t = 1'b0;
    for (n = 0; oe !== 1'b1 && n < 400; n++) @(negedge clk);
    lim(n, "slow refresh");
    until_done();
    {rc, susp_n} = {8'h00, 1'b1};
  endtask : t_susp

  initial begin
    int n, k;
    int l [4];
    repeat (3) @(negedge clk);
    chk("bus reset", 24'(brst), 24'h1);
    chk("refresh drive", 24'(oe), 24'h0);
    repeat (3) @(negedge clk);
    rstn = 1'b1;
    for (n = 0; brst !== 1'b0 && n < 400; n++) @(negedge clk);
    lim(n, "bus reset");
    chk("bus reset length", 24'(n >= 60 && n <= 72), 24'h1);
    for (k = 0; k < 8; k++) t_div(4'(k), (k < 4 ? 4 : 8) * ((k % 4) + 1));
    cc = 4'h0;
    t_ref(1'b0);
    t_ref(1'b1);
    t_cyc(1, 0, 0, 0, 24'h0FFFFF, 0, 0, 3'b001, l[0]);
    t_cyc(1, 0, 0, 0, 24'h0FFFFF, 0, 1, 3'b001, l[1]);
    chk("early end", 24'(l[1] < l[0]), 24'h1);
    t_cyc(1, 0, 0, 0, LOW_MEG_LIMIT, 1, 0, 3'b111, l[0]);
    t_cyc(1, 1, 0, 0, 24'h0ABCDE, 1, 0, 3'b110, l[0]);
    t_cyc(1, 1, 0, 0, LOW_MEG_LIMIT, 1, 0, 3'b111, l[0]);
    t_cyc(0, 0, 0, 0, 24'h000060, 0, 0, 3'b011, l[0]);
    t_cyc(1, 0, 1, 0, 24'h0FFFFE, 0, 0, 3'b101, l[2]);
    t_cyc(1, 0, 1, 0, 24'h0FFFFF, 1, 1, 3'b001, l[3]);
    chk("dma length", 24'(l[3] == l[2]), 24'h1);
    t_cyc(0, 1, 1, 1, 24'h000003, 1, 0, 3'b011, l[0]);
    t_susp();
    for (k = 0; k < 8; k++) begin
      tcin = 8'h01 << k;
      repeat (2) @(negedge clk);
      chk("terminal count", 24'(tc), 24'h1);
      tcin = 8'h00;
      repeat (2) @(negedge clk);
      chk("terminal count", 24'(tc), 24'h0);
    end
    final_report();
  end
endmodule : sbc_slot_ctl_bench

bind sbc_slot_ctl sbc_slot_ctl_properties chk_u (
  .i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_bus_osc_in(i_bus_osc_in),
  .i_refresh_control_reg(i_refresh_control_reg), .i_suspend_n(i_suspend_n),
  .i_dma_tc(i_dma_tc), .o_refresh_n(o_refresh_n), .o_refresh_oe(o_refresh_oe),
  .o_bus_clk(o_bus_clk), .o_bus_reset_out(o_bus_reset_out), .o_ale(o_ale),
  .o_memr_n(o_memr_n), .o_memw_n(o_memw_n), .o_smemr_n(o_smemr_n),
  .o_smemw_n(o_smemw_n), .o_slot_addr(o_slot_addr), .o_tc(o_tc),
  .o_ref_addr(o_ref_addr), .o_suspend_active(o_suspend_active),
  .o_cpu_clk_en(o_cpu_clk_en), .o_periph_clk_en(o_periph_clk_en));
`default_nettype wire
